// ==== rtl/dvs_defines.svh ====
`ifndef DVS_DEFINES_SVH
`define DVS_DEFINES_SVH

`define DVS_CLK_PERIOD_NS       4
`define DVS_SEL_FILTER_NS       90
`define DVS_SEL_FILTER_CYC      ((`DVS_SEL_FILTER_NS + `DVS_CLK_PERIOD_NS - 1) / `DVS_CLK_PERIOD_NS)
`define DVS_STORE_MIN_MS        3
`define DVS_STORE_MIN_CYC       ((`DVS_STORE_MIN_MS * 1000000) / `DVS_CLK_PERIOD_NS)
`define DVS_STORE_BUSY_MS       4
`define DVS_STORE_BUSY_CYC      ((`DVS_STORE_BUSY_MS * 1000000) / `DVS_CLK_PERIOD_NS)
`define DVS_DATA_BITS           8
`define DVS_ADDR_CH1            2'h0
`define DVS_ADDR_CH2            2'h1
`define DVS_BIT_CNT_LAST        3'h7
`define DVS_GAP_BITS            2'h2
`define DVS_NV_RESET            8'h80
`define DVS_SEL_CNT_W           5
`define DVS_BUSY_CNT_W          24

`define DVS_REG_IRQ_STATUS      4'h0
`define DVS_REG_IRQ_ENABLE      4'h4
`define DVS_REG_IRQ_CLEAR       4'h8
`define DVS_REG_CH1             4'hc
`define DVS_IRQ_W               3
`define DVS_IRQ_XFER            0
`define DVS_IRQ_STORE           1
`define DVS_IRQ_RELOAD          2

`endif

// ==== rtl/dvs_pkg.sv ====
package dvs_pkg;

    typedef enum logic [2:0]
    {
        DVS_IDLE  = 3'h0,
        DVS_ADDR0 = 3'h1,
        DVS_ADDR1 = 3'h2,
        DVS_DATA  = 3'h3,
        DVS_GAP   = 3'h4,
        DVS_STORE = 3'h5
    } dvs_state_t;

    typedef struct packed
    {
        logic [7:0] ch1;
        logic [7:0] ch2;
    } dvs_pair_t;

    typedef struct packed
    {
        logic [1:0] addr;
        logic [7:0] shift;
        logic [2:0] cnt;
    } dvs_frame_t;

endpackage

// ==== rtl/dvs_serial_ctrl.sv ====
// Notes on behaviour
// - Each of two channels holds an 8-bit setting, 256 steps.
// - After reset both channels load from non-volatile storage.
// - Channels are read and written independently; outputs change only at update or at the reload when select goes low.
// - Active settings change without touching stored values.
// - Address and data arrive least significant bit first.
// - A transfer begins only after a start bit of one.
// - Serial input is sampled on each rising serial clock edge.
// - Address 00 selects channel one, address 01 (first bit one, second bit zero) selects channel two.
// - While select is high and no store runs, transfers run and serial output is driven.
// - A shifted setting stays active while select remains high.
// - Select low reloads both channels and floats the serial output.
// - Low spikes on select shorter than the filter time are ignored.
// - The addressed output updates on the cycle after the eighth data bit.
// - During a store, done flag is low, input ignored, output silent.
// - Previously held value shifts out least significant bit first.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`include "dvs_defines.svh"

module dvs_serial_ctrl
(
    // Clock and reset.
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // Serial link, sampled on the rising clock edge.
    input  wire logic        select_in,
    input  wire logic        serial_in,
    input  wire logic        store_strobe_in,
    output logic             serial_out,
    output logic             serial_oe_n_out,
    output logic             store_done_flag_out,
    // Channel settings.
    output logic [7:0]       channel_one_output_out,
    output logic [7:0]       channel_two_output_out,
    output logic             irq_out,
    // AXI4-Lite slave.
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    dvs_pkg::dvs_state_t          state_reg,    state_next;
    dvs_pkg::dvs_frame_t          frame_reg,    frame_next;
    dvs_pkg::dvs_pair_t           active_reg,   active_next;
    dvs_pkg::dvs_pair_t           nv_reg,       nv_next;
    logic                         out_reg,      out_next;
    logic                         sel_reg,      sel_next;
    logic [`DVS_SEL_CNT_W-1:0]    sel_cnt_reg,  sel_cnt_next;
    logic [`DVS_BUSY_CNT_W-1:0]   busy_cnt_reg, busy_cnt_next;
    logic [1:0]                   gap_reg,      gap_next;
    logic                         store_strobe_reg,     store_strobe_next;
    logic [7:0]                   held_reg,     held_next;
    logic                         done_reg,     done_next;
    logic [`DVS_IRQ_W-1:0]        ev_status_reg, ev_status_next;
    logic [`DVS_IRQ_W-1:0]        ev_enable_reg, ev_enable_next;
    logic [`DVS_IRQ_W-1:0]        events;
    logic                         aw_reg,  aw_next;
    logic                         w_reg,   w_next;
    logic [3:0]                   awa_reg, awa_next;
    logic [31:0]                  wd_reg,  wd_next;
    logic                         bv_reg,  bv_next;
    logic                         rv_reg,  rv_next;
    logic [31:0]                  rd_reg,  rd_next;
    logic [`DVS_IRQ_W-1:0]        clr;

    function automatic logic [7:0] pick(input dvs_pkg::dvs_pair_t p, input logic [1:0] a);
        pick = (a == `DVS_ADDR_CH2) ? p.ch2 : p.ch1;
    endfunction

    // Select filter: the device sees select low only after it has stayed low for the
    // filter time, so a short glitch cannot wipe the temporary settings.
    always_comb
    begin
        sel_next     = sel_reg;
        sel_cnt_next = '0;
        if (select_in)
        begin
            sel_next = 1'b1;
        end
        else if (sel_reg)
        begin
            sel_cnt_next = sel_cnt_reg + 1'b1;
            if (sel_cnt_reg == `DVS_SEL_CNT_W'(`DVS_SEL_FILTER_CYC - 1))
            begin
                sel_next     = 1'b0;
                sel_cnt_next = '0;
            end
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            sel_reg     <= 1'b0;
            sel_cnt_reg <= '0;
        end
        else
        begin
            sel_reg     <= sel_next;
            sel_cnt_reg <= sel_cnt_next;
        end
    end

    // Serial engine.
    always_comb
    begin
        state_next    = state_reg;
        frame_next    = frame_reg;
        active_next   = active_reg;
        nv_next       = nv_reg;
        out_next      = out_reg;
        busy_cnt_next = busy_cnt_reg;
        gap_next      = gap_reg;
        store_strobe_next     = store_strobe_reg | store_strobe_in;
        held_next     = held_reg;
        done_next     = 1'b1;
        events        = '0;
        if (!sel_reg)
        begin
            active_next = nv_reg;
            if (state_reg != dvs_pkg::DVS_STORE)
            begin
                state_next = dvs_pkg::DVS_IDLE;
                store_strobe_next  = 1'b0;
            end
        end
        case (state_reg)
            dvs_pkg::DVS_IDLE:
            begin
                store_strobe_next = 1'b0;
                if (sel_reg && serial_in)
                begin
                    state_next = dvs_pkg::DVS_ADDR0;
                    store_strobe_next  = store_strobe_in;
                end
            end
            dvs_pkg::DVS_ADDR0:
            begin
                if (sel_reg)
                begin
                    frame_next.addr = {1'b0, serial_in};
                    state_next      = dvs_pkg::DVS_ADDR1;
                end
            end
            dvs_pkg::DVS_ADDR1:
            begin
                if (sel_reg)
                begin
                    frame_next.addr  = {serial_in, frame_reg.addr[0]};
                    frame_next.shift = pick(active_reg, {serial_in, frame_reg.addr[0]});
                    frame_next.cnt   = '0;
                    out_next         = frame_next.shift[0];
                    state_next       = dvs_pkg::DVS_DATA;
                end
            end
            dvs_pkg::DVS_DATA:
            begin
                if (sel_reg)
                begin
                    frame_next.shift = {serial_in, frame_reg.shift[7:1]};
                    frame_next.cnt   = frame_reg.cnt + 1'b1;
                    out_next         = frame_reg.shift[1];
                    if (frame_reg.cnt == `DVS_BIT_CNT_LAST)
                    begin
                        // Only the addressed register changes; the other stays put.
                        if (frame_reg.addr == `DVS_ADDR_CH1)
                            active_next.ch1 = frame_next.shift;
                        else if (frame_reg.addr == `DVS_ADDR_CH2)
                            active_next.ch2 = frame_next.shift;
                        held_next  = frame_next.shift;
                        events[`DVS_IRQ_XFER] = 1'b1;
                        gap_next   = '0;
                        state_next = dvs_pkg::DVS_GAP;
                    end
                end
            end
            dvs_pkg::DVS_GAP:
            begin
                gap_next = gap_reg + 1'b1;
                if (gap_reg == `DVS_GAP_BITS - 2'h1)
                begin
                    if (store_strobe_next && frame_reg.addr[1] == 1'b0)
                    begin
                        busy_cnt_next = '0;
                        state_next    = dvs_pkg::DVS_STORE;
                    end
                    else
                    begin
                        state_next = dvs_pkg::DVS_IDLE;
                    end
                end
            end
            dvs_pkg::DVS_STORE:
            begin
                done_next     = 1'b0;
                busy_cnt_next = busy_cnt_reg + 1'b1;
                if (busy_cnt_reg == `DVS_BUSY_CNT_W'(`DVS_STORE_BUSY_CYC - 1))
                begin
                    if (frame_reg.addr == `DVS_ADDR_CH1)
                        nv_next.ch1 = held_reg;
                    else
                        nv_next.ch2 = held_reg;
                    events[`DVS_IRQ_STORE] = 1'b1;
                    done_next  = 1'b1;
                    store_strobe_next  = 1'b0;
                    state_next = dvs_pkg::DVS_IDLE;
                end
            end
            default:
            begin
                state_next = dvs_pkg::DVS_IDLE;
            end
        endcase
        if (sel_reg && !sel_next)
            events[`DVS_IRQ_RELOAD] = 1'b1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            state_reg    <= dvs_pkg::DVS_IDLE;
            frame_reg    <= '0;
            active_reg   <= {`DVS_NV_RESET, `DVS_NV_RESET};
            nv_reg       <= {`DVS_NV_RESET, `DVS_NV_RESET};
            out_reg      <= 1'b0;
            busy_cnt_reg <= '0;
            gap_reg      <= '0;
            store_strobe_reg     <= 1'b0;
            held_reg     <= '0;
            done_reg     <= 1'b1;
        end
        else
        begin
            state_reg    <= state_next;
            frame_reg    <= frame_next;
            active_reg   <= active_next;
            nv_reg       <= nv_next;
            out_reg      <= out_next;
            busy_cnt_reg <= busy_cnt_next;
            gap_reg      <= gap_next;
            store_strobe_reg     <= store_strobe_next;
            held_reg     <= held_next;
            done_reg     <= done_next;
        end
    end

    assign serial_out             = out_reg;
    // Output driven (enable low) while selected and not storing.
    assign serial_oe_n_out        = !(sel_reg && state_reg != dvs_pkg::DVS_STORE);
    assign store_done_flag_out    = done_reg;
    assign channel_one_output_out = active_reg.ch1;
    assign channel_two_output_out = active_reg.ch2;

    // AXI4-Lite register slave with interrupt status, enable and clear.
    always_comb
    begin
        aw_next  = aw_reg;
        w_next   = w_reg;
        awa_next = awa_reg;
        wd_next  = wd_reg;
        bv_next  = bv_reg;
        rv_next  = rv_reg;
        rd_next  = rd_reg;
        clr      = '0;
        ev_enable_next = ev_enable_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_next  = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_next  = 1'b1;
            wd_next = s_axi_wdata;
        end
        if (aw_reg && w_reg)
        begin
            aw_next = 1'b0;
            w_next  = 1'b0;
            bv_next = 1'b1;
            if (awa_reg == `DVS_REG_IRQ_ENABLE)
                ev_enable_next = wd_reg[`DVS_IRQ_W-1:0];
            else if (awa_reg == `DVS_REG_IRQ_CLEAR)
                clr = wd_reg[`DVS_IRQ_W-1:0];
        end
        if (s_axi_bvalid && s_axi_bready)
            bv_next = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rv_next = 1'b1;
            case (s_axi_araddr)
                `DVS_REG_IRQ_STATUS: rd_next = {29'h0, ev_status_reg};
                `DVS_REG_IRQ_ENABLE: rd_next = {29'h0, ev_enable_reg};
                `DVS_REG_CH1:        rd_next = {16'h0, active_reg.ch2, active_reg.ch1};
                default:             rd_next = 32'h0;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready)
            rv_next = 1'b0;
        // A new event beats a clear arriving in the same cycle.
        ev_status_next = (ev_status_reg & ~clr) | events;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            aw_reg        <= 1'b0;
            w_reg         <= 1'b0;
            awa_reg       <= '0;
            wd_reg        <= '0;
            bv_reg        <= 1'b0;
            rv_reg        <= 1'b0;
            rd_reg        <= '0;
            ev_status_reg <= '0;
            ev_enable_reg <= '0;
        end
        else
        begin
            aw_reg        <= aw_next;
            w_reg         <= w_next;
            awa_reg       <= awa_next;
            wd_reg        <= wd_next;
            bv_reg        <= bv_next;
            rv_reg        <= rv_next;
            rd_reg        <= rd_next;
            ev_status_reg <= ev_status_next;
            ev_enable_reg <= ev_enable_next;
        end
    end

    assign s_axi_awready = !aw_reg && !bv_reg;
    assign s_axi_wready  = !w_reg && !bv_reg;
    assign s_axi_bvalid  = bv_reg;
    assign s_axi_bresp   = 2'h0;
    assign s_axi_arready = !rv_reg;
    assign s_axi_rvalid  = rv_reg;
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = 2'h0;
    assign irq_out       = |(ev_status_reg & ev_enable_reg);

    property p_oe_follows_sel;
        @(posedge ref_clk_in) disable iff (rst_in)
        (!sel_reg) |-> serial_oe_n_out;
    endproperty
    a_oe_follows_sel: assert property (p_oe_follows_sel) else $error("output driven unselected");

    property p_reload;
        @(posedge ref_clk_in) disable iff (rst_in)
        (!sel_reg && state_reg != dvs_pkg::DVS_STORE) |=> (active_reg == $past(nv_reg));
    endproperty
    a_reload: assert property (p_reload) else $error("no reload when deselected");

    property p_store_busy;
        @(posedge ref_clk_in) disable iff (rst_in)
        (state_reg == dvs_pkg::DVS_STORE && busy_cnt_reg != '0) |-> !store_done_flag_out;
    endproperty
    a_store_busy: assert property (p_store_busy) else $error("done flag high in store");

    property p_start;
        @(posedge ref_clk_in) disable iff (rst_in)
        (state_reg == dvs_pkg::DVS_IDLE && !serial_in) |=> state_reg == dvs_pkg::DVS_IDLE;
    endproperty
    a_start: assert property (p_start) else $error("started without start bit");

    property p_update;
        @(posedge ref_clk_in) disable iff (rst_in)
        (sel_reg && select_in && state_reg == dvs_pkg::DVS_DATA
         && frame_reg.cnt == `DVS_BIT_CNT_LAST && frame_reg.addr == `DVS_ADDR_CH1)
        |=> channel_one_output_out == {$past(serial_in), $past(frame_reg.shift[7:1])};
    endproperty
    a_update: assert property (p_update) else $error("channel one not updated");

    property p_bad_addr;
        @(posedge ref_clk_in) disable iff (rst_in)
        (sel_reg && select_in && state_reg == dvs_pkg::DVS_DATA && frame_reg.addr[1])
        |=> $stable(active_reg);
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("bad address changed setting");

    property p_filter;
        @(posedge ref_clk_in) disable iff (rst_in)
        (sel_reg && !select_in ##1 select_in) |-> sel_reg;
    endproperty
    a_filter: assert property (p_filter) else $error("short spike dropped select");

    property p_shift_out;
        @(posedge ref_clk_in) disable iff (rst_in)
        (sel_reg && select_in && state_reg == dvs_pkg::DVS_DATA && frame_reg.cnt != `DVS_BIT_CNT_LAST)
        |=> serial_out == $past(frame_reg.shift[1]);
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("read bit wrong");

endmodule

// ==== tb/dvs_host_model.sv ====
module dvs_host_model
(
    // Clock shared with the block.
    input  wire logic       ref_clk_in,
    // Observed lines.
    input  wire logic       serial_line_in,
    input  wire logic [7:0] ch_one_in,
    input  wire logic [7:0] ch_two_in,
    // Driven lines.
    output logic            select_out,
    output logic            serial_out,
    output logic            store_strobe_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        select_out       = 1'b0;
        serial_out       = 1'b0;
        store_strobe_out = 1'b0;
    end

    // Only this one device sits on the shared lines, so its select is the only one raised.
    task automatic set_select(input logic lvl, input int hold);
        @(posedge ref_clk_in);
        select_out <= lvl;
        repeat (hold) @(posedge ref_clk_in);
    endtask

    // Bits go out as {data, second address bit, first address bit, start}, index 0 first.
    // The read value is taken from the shared line, so a floated line never matches.
    task automatic xfer(input logic [10:0] bits, input logic strobe,
                        output logic [7:0] rd, output logic steady);
        logic [7:0] ch1_0;
        logic [7:0] ch2_0;
        ch1_0  = ch_one_in;
        ch2_0  = ch_two_in;
        steady = 1'b1;
        rd     = 8'h00;
        @(posedge ref_clk_in);
        serial_out <= 1'b0;
        for (int i = 0; i < 11; i++)
        begin
            @(posedge ref_clk_in);
            serial_out <= bits[i];
            if (strobe)
                store_strobe_out <= 1'b1;
            @(negedge ref_clk_in);
            if (i >= 3)
                rd[i - 3] = serial_line_in;
            if (ch_one_in !== ch1_0 || ch_two_in !== ch2_0)
                steady = 1'b0;
        end
        @(posedge ref_clk_in);
        serial_out <= 1'b0;
        @(negedge ref_clk_in);
    endtask
endmodule

// ==== tb/dvs_serial_ctrl_tb.sv ====
`include "dvs_defines.svh"

module dvs_serial_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk_in, rst_in;
    wire         host_sel, host_data, host_strobe, serial_line;
    logic        serial_out, serial_oe_n_out, store_done_flag_out, irq_out;
    logic [7:0]  channel_one_output_out, channel_two_output_out;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          err_count, checked;
    logic [7:0]  rd;
    logic        steady;

    assign serial_line = serial_oe_n_out ? 1'bz : serial_out;

    dvs_serial_ctrl dut
    (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .select_in(host_sel),
        .serial_in(host_data), .store_strobe_in(host_strobe), .serial_out(serial_out),
        .serial_oe_n_out(serial_oe_n_out), .store_done_flag_out(store_done_flag_out),
        .channel_one_output_out(channel_one_output_out),
        .channel_two_output_out(channel_two_output_out), .irq_out(irq_out),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    dvs_host_model host
    (
        .ref_clk_in(ref_clk_in), .serial_line_in(serial_line),
        .ch_one_in(channel_one_output_out), .ch_two_in(channel_two_output_out),
        .select_out(host_sel), .serial_out(host_data), .store_strobe_out(host_strobe)
    );

    initial
    begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic axi_write(input logic [3:0] addr, input logic [31:0] data);
        logic       aw_pend;
        logic       w_pend;
        logic [1:0] resp;
        @(posedge ref_clk_in);
        s_axi_awaddr  <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= data;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        aw_pend = 1'b1;
        w_pend  = 1'b1;
        forever
        begin
            @(posedge ref_clk_in);
            if (!aw_pend && !w_pend && s_axi_bvalid === 1'b1)
            begin
                resp = s_axi_bresp;
                break;
            end
            if (aw_pend && s_axi_awready === 1'b1)
            begin
                aw_pend = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_pend && s_axi_wready === 1'b1)
            begin
                w_pend = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        chk({30'h0, resp}, 32'h0, "write response");
    endtask

    task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp, input string msg);
        logic        ar_pend;
        logic [31:0] data;
        logic [1:0]  resp;
        @(posedge ref_clk_in);
        s_axi_araddr  <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        ar_pend = 1'b1;
        forever
        begin
            @(posedge ref_clk_in);
            if (!ar_pend && s_axi_rvalid === 1'b1)
            begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                break;
            end
            if (ar_pend && s_axi_arready === 1'b1)
            begin
                ar_pend = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
        s_axi_rready <= 1'b0;
        chk(data, exp, msg);
        chk({30'h0, resp}, 32'h0, "read response");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk_in);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end

    initial
    begin
        err_count = 0;
        checked = 0;
        rst_in = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(negedge ref_clk_in);
        chk(channel_one_output_out, `DVS_NV_RESET, "ch1 at reset");
        chk(channel_two_output_out, `DVS_NV_RESET, "ch2 at reset");
        chk(store_done_flag_out, 1'b1, "done at reset");
        chk(serial_oe_n_out, 1'b1, "output floated at reset");
        chk(irq_out, 1'b0, "irq at reset");
        $display("test reset done");

        axi_write(`DVS_REG_IRQ_CLEAR, 32'h7);
        rd_chk(`DVS_REG_IRQ_STATUS, 32'h0, "status cleared");
        rd_chk(`DVS_REG_IRQ_CLEAR, 32'h0, "clear reads zero");
        axi_write(`DVS_REG_IRQ_STATUS, 32'h7);
        rd_chk(`DVS_REG_IRQ_STATUS, 32'h0, "status is read-only");
        axi_write(`DVS_REG_IRQ_ENABLE, 32'h7);
        rd_chk(`DVS_REG_IRQ_ENABLE, 32'h7, "enable readback");
        $display("test registers done");

        // Two frames with the minimum gap between them.
        host.set_select(1'b1, 0);
        host.xfer({8'h3c, 2'b00, 1'b1}, 1'b0, rd, steady);
        chk(rd, `DVS_NV_RESET, "ch1 old value out");
        chk(steady, 1'b1, "outputs moved mid-frame");
        chk(channel_one_output_out, 8'h3c, "ch1 update");
        chk(channel_two_output_out, `DVS_NV_RESET, "ch2 untouched");
        host.xfer({8'ha5, 2'b01, 1'b1}, 1'b0, rd, steady);
        chk(rd, `DVS_NV_RESET, "ch2 old value out");
        chk(channel_two_output_out, 8'ha5, "ch2 update");
        chk(channel_one_output_out, 8'h3c, "ch1 kept");
        rd_chk(`DVS_REG_IRQ_STATUS, 32'h1, "transfer event");
        @(negedge ref_clk_in);
        chk(irq_out, 1'b1, "irq raised");
        rd_chk(`DVS_REG_CH1, 32'h0000a53c, "channel readback");
        $display("test write done");

        for (int a = 2; a < 4; a++)
        begin
            host.xfer({8'h11, a[1:0], 1'b1}, 1'b0, rd, steady);
            chk(channel_one_output_out, 8'h3c, "ch1 after bad address");
            chk(channel_two_output_out, 8'ha5, "ch2 after bad address");
        end
        host.xfer(11'h000, 1'b0, rd, steady);
        repeat (4) @(negedge ref_clk_in);
        chk(channel_one_output_out, 8'h3c, "frame without start taken");
        host.set_select(1'b0, 4);
        host.set_select(1'b1, 30);
        @(negedge ref_clk_in);
        chk(channel_one_output_out, 8'h3c, "ch1 after spike");
        chk(channel_two_output_out, 8'ha5, "ch2 after spike");
        $display("test refusals done");

        host.set_select(1'b0, 30);
        @(negedge ref_clk_in);
        chk(channel_one_output_out, `DVS_NV_RESET, "ch1 reload");
        chk(channel_two_output_out, `DVS_NV_RESET, "ch2 reload");
        chk(serial_oe_n_out, 1'b1, "output floated");
        rd_chk(`DVS_REG_IRQ_STATUS, 32'h5, "reload event");
        axi_write(`DVS_REG_IRQ_CLEAR, 32'h1);
        rd_chk(`DVS_REG_IRQ_STATUS, 32'h4, "clear one bit");
        axi_write(`DVS_REG_IRQ_ENABLE, 32'h1);
        repeat (2) @(negedge ref_clk_in);
        chk(irq_out, 1'b0, "irq masked");
        axi_write(`DVS_REG_IRQ_ENABLE, 32'h4);
        repeat (2) @(negedge ref_clk_in);
        chk(irq_out, 1'b1, "irq enabled");
        axi_write(`DVS_REG_IRQ_CLEAR, 32'h4);
        repeat (2) @(negedge ref_clk_in);
        chk(irq_out, 1'b0, "irq cleared");
        $display("test deselect done");

        host.set_select(1'b1, 0);
        host.xfer({8'h5a, 2'b00, 1'b1}, 1'b1, rd, steady);
        chk(rd, `DVS_NV_RESET, "stored value out");
        chk(channel_one_output_out, 8'h5a, "ch1 before store");
        for (int n = 0; n < 6 && store_done_flag_out !== 1'b0; n++)
            @(negedge ref_clk_in);
        chk(store_done_flag_out, 1'b0, "store not started");
        chk(serial_oe_n_out, 1'b1, "output driven in store");
        host.xfer({8'h33, 2'b01, 1'b1}, 1'b1, rd, steady);
        chk(channel_two_output_out, `DVS_NV_RESET, "input taken in store");
        chk(store_done_flag_out, 1'b0, "store ended early");
        $display("test store done");
        give_verdict();
    end
endmodule
